// ### rtl/cpu8_regmem_rmw_decode_pkg.sv
package cpu8_regmem_rmw_decode_pkg;

  localparam logic [15:0] RESET_PC_DEFAULT = 16'h0000;
  localparam logic [9:0] STACK_PAGE = 10'h003;
  localparam logic [5:0] SP_RESET = 6'h3f;

  localparam int CCR_H = 4;
  localparam int CCR_I = 3;
  localparam int CCR_N = 2;
  localparam int CCR_Z = 1;
  localparam int CCR_C = 0;
  localparam logic [4:0] CCR_RESET = 5'h08;

  // Upper opcode nibble of the register/memory group
  localparam logic [3:0] NIB_IMM = 4'ha;
  localparam logic [3:0] NIB_DIR = 4'hb;
  localparam logic [3:0] NIB_EXT = 4'hc;
  localparam logic [3:0] NIB_IX2 = 4'hd;
  localparam logic [3:0] NIB_IX1 = 4'he;
  localparam logic [3:0] NIB_IX = 4'hf;

  // Upper opcode nibble of the read/modify/write group
  localparam logic [3:0] NIB_RMW_DIR = 4'h3;
  localparam logic [3:0] NIB_RMW_INHA = 4'h4;
  localparam logic [3:0] NIB_RMW_INHX = 4'h5;
  localparam logic [3:0] NIB_RMW_IX1 = 4'h6;
  localparam logic [3:0] NIB_RMW_IX = 4'h7;

  localparam logic [7:0] OP_MUL = 8'h42;
  localparam logic [7:0] OP_TAX = 8'h97;
  localparam logic [7:0] OP_CLC = 8'h98;
  localparam logic [7:0] OP_SEC = 8'h99;
  localparam logic [7:0] OP_CLI = 8'h9a;
  localparam logic [7:0] OP_SEI = 8'h9b;
  localparam logic [7:0] OP_RSP = 8'h9c;
  localparam logic [7:0] OP_NOP = 8'h9d;
  localparam logic [7:0] OP_TXA = 8'h9f;

  // Instruction lengths in clock cycles
  localparam logic [3:0] LEN_IMM = 4'h2;
  localparam logic [3:0] LEN_DIR = 4'h3;
  localparam logic [3:0] LEN_EXT = 4'h4;
  localparam logic [3:0] LEN_IX = 4'h3;
  localparam logic [3:0] LEN_IX1 = 4'h4;
  localparam logic [3:0] LEN_IX2 = 4'h5;
  localparam logic [3:0] LEN_RMW_INH = 4'h3;
  localparam logic [3:0] LEN_RMW_SHORT = 4'h5;
  localparam logic [3:0] LEN_RMW_IX1 = 4'h6;
  localparam logic [3:0] LEN_MUL = 4'hb;
  localparam logic [3:0] LEN_CTRL = 4'h2;
  localparam logic [3:0] LEN_ILL = 4'h2;

  typedef enum logic [2:0] {
    MODE_INH = 3'h0, MODE_IMM = 3'h1, MODE_DIR = 3'h2, MODE_EXT = 3'h3,
    MODE_IX = 3'h4, MODE_IX1 = 3'h5, MODE_IX2 = 3'h6
  } mode_type;

  typedef enum logic [3:0] {
    CLS_REGMEM = 4'h0, CLS_STORE = 4'h1, CLS_JMP = 4'h2, CLS_JSR = 4'h3,
    CLS_RMW = 4'h4, CLS_MUL = 4'h5, CLS_CTRL = 4'h6, CLS_ILL = 4'h7
  } class_type;

  typedef enum logic [4:0] {
    ALU_LD = 5'h00, ALU_ADD = 5'h01, ALU_ADC = 5'h02, ALU_SUB = 5'h03,
    ALU_SBC = 5'h04, ALU_AND = 5'h05, ALU_ORA = 5'h06, ALU_EOR = 5'h07,
    ALU_NEG = 5'h08, ALU_COM = 5'h09, ALU_LSR = 5'h0a, ALU_ROR = 5'h0b,
    ALU_ASR = 5'h0c, ALU_LSL = 5'h0d, ALU_ROL = 5'h0e, ALU_DEC = 5'h0f,
    ALU_INC = 5'h10, ALU_CLR = 5'h11, ALU_TST = 5'h12
  } alu_op_type;

  typedef enum logic {ST_FETCH = 1'b0, ST_EXEC = 1'b1} state_type;

endpackage : cpu8_regmem_rmw_decode_pkg

// ### rtl/cpu8_alu.sv
`timescale 1ns/1ps
module cpu8_alu
  import cpu8_regmem_rmw_decode_pkg::*;
(
  input wire alu_op_type op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic cin_in,
  output logic [7:0] res_out,
  output logic n_out,
  output logic z_out,
  output logic h_out,
  output logic c_out,
  output logic h_we_out,
  output logic c_we_out
);

  logic [8:0] s;

  always_comb begin
    s = 9'h000;
    res_out = 8'h00;
    h_out = 1'b0;
    c_out = cin_in;
    h_we_out = 1'b0;
    c_we_out = 1'b0;
    case (op_in)
      ALU_ADD, ALU_ADC: begin
        s = {1'b0, a_in} + {1'b0, b_in} + {8'h00, (op_in == ALU_ADC) & cin_in};
        res_out = s[7:0];
        c_out = s[8];
        h_out = a_in[4] ^ b_in[4] ^ s[4];
        h_we_out = 1'b1;
        c_we_out = 1'b1;
      end
      ALU_SUB, ALU_SBC: begin
        s = {1'b0, a_in} - {1'b0, b_in} - {8'h00, (op_in == ALU_SBC) & cin_in};
        res_out = s[7:0];
        c_out = s[8];
        c_we_out = 1'b1;
      end
      ALU_AND: res_out = a_in & b_in;
      ALU_ORA: res_out = a_in | b_in;
      ALU_EOR: res_out = a_in ^ b_in;
      ALU_NEG: begin
        s = 9'h000 - {1'b0, b_in};
        res_out = s[7:0];
        c_out = (s[7:0] != 8'h00);
        c_we_out = 1'b1;
      end
      ALU_COM: begin
        res_out = ~b_in;
        c_out = 1'b1;
        c_we_out = 1'b1;
      end
      ALU_LSR: begin
        res_out = {1'b0, b_in[7:1]};
        c_out = b_in[0];
        c_we_out = 1'b1;
      end
      ALU_ROR: begin
        res_out = {cin_in, b_in[7:1]};
        c_out = b_in[0];
        c_we_out = 1'b1;
      end
      ALU_ASR: begin
        res_out = {b_in[7], b_in[7:1]};
        c_out = b_in[0];
        c_we_out = 1'b1;
      end
      ALU_LSL: begin
        res_out = {b_in[6:0], 1'b0};
        c_out = b_in[7];
        c_we_out = 1'b1;
      end
      ALU_ROL: begin
        res_out = {b_in[6:0], cin_in};
        c_out = b_in[7];
        c_we_out = 1'b1;
      end
      ALU_DEC: res_out = b_in - 8'h01;
      ALU_INC: res_out = b_in + 8'h01;
      ALU_CLR: res_out = 8'h00;
      default: res_out = b_in;
    endcase
    n_out = res_out[7];
    z_out = (res_out == 8'h00);
  end

endmodule : cpu8_alu

// ### rtl/cpu8_regmem_rmw_decode.sv
// Contract
// [RULE1] Modify class reads, alters, writes same place
// [RULE2] Test instruction updates flags, never writes back
// [RULE3] Control instructions touch only internal registers
// [RULE4] Multiply forms 16-bit product, clears H and C
// [RULE5] Upper nibble selects mode and cycle count
// [RULE6] Add with carry sums accumulator, operand, carry
// [RULE7] Accumulator compare sets flags, keeps accumulator
// [RULE8] Index compare sets flags, keeps index
// [RULE9] Bit test ANDs, sets flags, discards result
// [RULE10] Exclusive-or folds operand into accumulator
// [RULE11] Stores lack immediate, take one extra cycle
// [RULE12] Jump loads PC; call pushes return first
// [RULE13] Product high byte to index, low to accumulator
// [RULE14] Test lengths: inherent 3, short 4, offset 5
`timescale 1ns/1ps
module cpu8_regmem_rmw_decode
  import cpu8_regmem_rmw_decode_pkg::*;
#(
  parameter logic [15:0] RESET_PC = RESET_PC_DEFAULT
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [7:0] mem_rdata_in,
  output logic [15:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [7:0] mem_wdata_out,
  output logic [7:0] acc_out,
  output logic [7:0] index_out,
  output logic [15:0] pc_out,
  output logic [4:0] ccr_out,
  output logic instr_done_out,
  output logic illegal_out
);

  state_type state_q;
  logic [3:0] step_q;
  logic [7:0] opcode_q, acc_q, x_q, b1_q, b2_q, opnd_q;
  logic [15:0] pc_q;
  logic [5:0] sp_q;
  logic [4:0] ccr_q;
  logic done_q, illegal_q;

  class_type cls;
  mode_type mode;
  alu_op_type op;
  logic dest_x, wr_reg;
  logic [3:0] len, nbytes;
  logic [3:0] lo, hi;

  // Decode is driven from the latched opcode; it is only used in the execute state
  always_comb begin
    lo = opcode_q[3:0];
    hi = opcode_q[7:4];
    cls = CLS_ILL;
    mode = MODE_INH;
    op = ALU_LD;
    dest_x = 1'b0;
    wr_reg = 1'b0;
    len = LEN_ILL;
    if (hi >= NIB_IMM) begin
      cls = CLS_REGMEM;
      case (hi) // see [RULE5]
        NIB_IMM: begin mode = MODE_IMM; len = LEN_IMM; end
        NIB_DIR: begin mode = MODE_DIR; len = LEN_DIR; end
        NIB_EXT: begin mode = MODE_EXT; len = LEN_EXT; end
        NIB_IX2: begin mode = MODE_IX2; len = LEN_IX2; end
        NIB_IX1: begin mode = MODE_IX1; len = LEN_IX1; end
        default: begin mode = MODE_IX; len = LEN_IX; end
      endcase
      case (lo)
        4'h0: begin op = ALU_SUB; wr_reg = 1'b1; end
        4'h1: op = ALU_SUB; // see [RULE7]
        4'h2: begin op = ALU_SBC; wr_reg = 1'b1; end
        4'h3: begin op = ALU_SUB; dest_x = 1'b1; end // see [RULE8]
        4'h4: begin op = ALU_AND; wr_reg = 1'b1; end
        4'h5: op = ALU_AND; // see [RULE9]
        4'h6: wr_reg = 1'b1;
        4'h7: begin cls = CLS_STORE; len = len + 4'h1; end // see [RULE11]
        4'h8: begin op = ALU_EOR; wr_reg = 1'b1; end // see [RULE10]
        4'h9: begin op = ALU_ADC; wr_reg = 1'b1; end // see [RULE6]
        4'ha: begin op = ALU_ORA; wr_reg = 1'b1; end
        4'hb: begin op = ALU_ADD; wr_reg = 1'b1; end
        4'hc: begin cls = CLS_JMP; len = len - 4'h1; end // see [RULE12]
        4'hd: begin cls = CLS_JSR; len = len + 4'h2; end // see [RULE12]
        4'he: begin dest_x = 1'b1; wr_reg = 1'b1; end
        default: begin cls = CLS_STORE; dest_x = 1'b1; len = len + 4'h1; end // see [RULE11]
      endcase
      // No immediate form exists for stores, jumps or calls (AD is a branch)
      if (mode == MODE_IMM && cls != CLS_REGMEM) begin // see [RULE11]
        cls = CLS_ILL;
        mode = MODE_INH;
        len = LEN_ILL;
      end
    end else if (opcode_q == OP_MUL) begin
      cls = CLS_MUL;
      len = LEN_MUL;
    end else if (hi >= NIB_RMW_DIR && hi <= NIB_RMW_IX) begin
      cls = CLS_RMW;
      case (hi)
        NIB_RMW_DIR: begin mode = MODE_DIR; len = LEN_RMW_SHORT; end
        NIB_RMW_INHA: len = LEN_RMW_INH;
        NIB_RMW_INHX: begin dest_x = 1'b1; len = LEN_RMW_INH; end
        NIB_RMW_IX1: begin mode = MODE_IX1; len = LEN_RMW_IX1; end
        default: begin mode = MODE_IX; len = LEN_RMW_SHORT; end
      endcase
      case (lo)
        4'h0: op = ALU_NEG;
        4'h3: op = ALU_COM;
        4'h4: op = ALU_LSR;
        4'h6: op = ALU_ROR;
        4'h7: op = ALU_ASR;
        4'h8: op = ALU_LSL;
        4'h9: op = ALU_ROL;
        4'ha: op = ALU_DEC;
        4'hc: op = ALU_INC;
        4'hd: op = ALU_TST;
        4'hf: op = ALU_CLR;
        default: cls = CLS_ILL;
      endcase
      // The test skips the write-back cycle when it reads memory
      if (op == ALU_TST && mode != MODE_INH) begin // see [RULE14]
        len = len - 4'h1;
      end
      if (cls == CLS_ILL) begin
        mode = MODE_INH;
        len = LEN_ILL;
      end
    end else if (opcode_q == OP_TAX || opcode_q == OP_TXA || opcode_q == OP_NOP || opcode_q == OP_RSP ||
                 (opcode_q >= OP_CLC && opcode_q <= OP_SEI)) begin
      cls = CLS_CTRL;
      len = LEN_CTRL;
    end
  end

  always_comb begin
    case (mode)
      MODE_IMM, MODE_DIR, MODE_IX1: nbytes = 4'h1;
      MODE_EXT, MODE_IX2: nbytes = 4'h2;
      default: nbytes = 4'h0;
    endcase
  end

  logic exec, last, byte_step, rmw_mem, is_tst;
  logic [7:0] b1, b2, reg_val;
  logic [15:0] ea;

  assign exec = (state_q == ST_EXEC);
  assign last = exec && (step_q == len - 4'h1);
  assign byte_step = exec && (step_q <= nbytes);
  assign rmw_mem = (cls == CLS_RMW) && (mode != MODE_INH);
  assign is_tst = (op == ALU_TST);
  assign reg_val = dest_x ? x_q : acc_q;
  // Address bytes are used in the cycle they arrive so short jumps meet their length
  assign b1 = (step_q == 4'h1) ? mem_rdata_in : b1_q;
  assign b2 = (step_q == 4'h2) ? mem_rdata_in : b2_q;

  always_comb begin
    case (mode)
      MODE_DIR: ea = {8'h00, b1};
      MODE_EXT: ea = {b1, b2};
      MODE_IX: ea = {8'h00, x_q};
      MODE_IX1: ea = {8'h00, b1} + {8'h00, x_q};
      MODE_IX2: ea = {b1, b2} + {8'h00, x_q};
      default: ea = pc_q;
    endcase
  end

  logic [7:0] alu_b, alu_res;
  logic alu_n, alu_z, alu_h, alu_c, alu_h_we, alu_c_we;

  always_comb begin
    if (cls == CLS_REGMEM || (rmw_mem && is_tst)) begin
      alu_b = mem_rdata_in;
    end else if (rmw_mem) begin
      alu_b = opnd_q;
    end else begin
      alu_b = reg_val;
    end
  end

  cpu8_alu u_alu (
    .op_in(op),
    .a_in(reg_val),
    .b_in(alu_b),
    .cin_in(ccr_q[CCR_C]),
    .res_out(alu_res),
    .n_out(alu_n),
    .z_out(alu_z),
    .h_out(alu_h),
    .c_out(alu_c),
    .h_we_out(alu_h_we),
    .c_we_out(alu_c_we)
  );

  // Memory sees one access per cycle; read data is expected in the same cycle
  always_comb begin
    mem_addr_out = pc_q;
    mem_rd_out = 1'b0;
    mem_wr_out = 1'b0;
    mem_wdata_out = 8'h00;
    if (!exec || byte_step) begin
      mem_rd_out = 1'b1;
    end else begin
      case (cls)
        CLS_REGMEM: begin
          mem_addr_out = ea;
          mem_rd_out = last;
        end
        CLS_STORE: begin
          mem_addr_out = ea;
          mem_wr_out = last;
          mem_wdata_out = reg_val;
        end
        CLS_RMW: begin
          mem_addr_out = ea;
          if (rmw_mem && is_tst) begin
            mem_rd_out = last; // see [RULE2]
          end else if (rmw_mem) begin
            mem_rd_out = (step_q == len - 4'h2); // see [RULE1]
            mem_wr_out = last;
            mem_wdata_out = alu_res;
          end
        end
        CLS_JSR: begin
          mem_addr_out = {STACK_PAGE, sp_q};
          mem_wr_out = (step_q == len - 4'h3) || (step_q == len - 4'h2); // see [RULE12]
          mem_wdata_out = (step_q == len - 4'h3) ? pc_q[7:0] : pc_q[15:8];
        end
        default: mem_addr_out = pc_q; // see [RULE3]
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_q <= ST_FETCH;
      step_q <= 4'h0;
    end else if (!exec) begin
      state_q <= ST_EXEC;
      step_q <= 4'h1;
    end else if (last) begin
      state_q <= ST_FETCH;
      step_q <= 4'h0;
    end else begin
      step_q <= step_q + 4'h1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      opcode_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      opnd_q <= 8'h00;
    end else begin
      if (!exec) begin
        opcode_q <= mem_rdata_in;
      end
      if (byte_step && step_q == 4'h1) begin
        b1_q <= mem_rdata_in;
      end
      if (byte_step && step_q == 4'h2) begin
        b2_q <= mem_rdata_in;
      end
      if (mem_rd_out && rmw_mem && exec) begin
        opnd_q <= mem_rdata_in;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pc_q <= RESET_PC;
    end else if (last && (cls == CLS_JMP || cls == CLS_JSR)) begin
      pc_q <= ea; // see [RULE12]
    end else if (!exec || byte_step) begin
      pc_q <= pc_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sp_q <= SP_RESET;
    end else if (last && opcode_q == OP_RSP) begin
      sp_q <= SP_RESET;
    end else if (exec && cls == CLS_JSR && mem_wr_out) begin
      sp_q <= sp_q - 6'h01; // Wraps inside the 64-byte stack page
    end
  end

  logic [15:0] product;
  assign product = {8'h00, x_q} * {8'h00, acc_q};

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      acc_q <= 8'h00;
      x_q <= 8'h00;
    end else if (last) begin
      if (cls == CLS_MUL) begin
        x_q <= product[15:8]; // see [RULE4] [RULE13]
        acc_q <= product[7:0]; // see [RULE13]
      end else if (cls == CLS_CTRL && opcode_q == OP_TAX) begin
        x_q <= acc_q;
      end else if (cls == CLS_CTRL && opcode_q == OP_TXA) begin
        acc_q <= x_q;
      end else if ((cls == CLS_REGMEM && wr_reg) || (cls == CLS_RMW && !rmw_mem && !is_tst)) begin
        if (dest_x) begin
          x_q <= alu_res;
        end else begin
          acc_q <= alu_res; // see [RULE6] [RULE10]
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ccr_q <= CCR_RESET;
    end else if (last) begin
      case (cls)
        CLS_REGMEM, CLS_STORE, CLS_RMW: begin
          ccr_q[CCR_N] <= alu_n; // see [RULE2] [RULE9]
          ccr_q[CCR_Z] <= alu_z;
          if (alu_h_we) begin
            ccr_q[CCR_H] <= alu_h;
          end
          if (alu_c_we) begin
            ccr_q[CCR_C] <= alu_c;
          end
        end
        CLS_MUL: begin
          ccr_q[CCR_H] <= 1'b0; // see [RULE4]
          ccr_q[CCR_C] <= 1'b0;
        end
        CLS_CTRL: begin
          if (opcode_q == OP_CLC || opcode_q == OP_SEC) begin
            ccr_q[CCR_C] <= (opcode_q == OP_SEC);
          end
          if (opcode_q == OP_CLI || opcode_q == OP_SEI) begin
            ccr_q[CCR_I] <= (opcode_q == OP_SEI);
          end
        end
        default: ccr_q <= ccr_q;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      done_q <= last;
      illegal_q <= last && (cls == CLS_ILL);
    end
  end

  assign acc_out = acc_q;
  assign index_out = x_q;
  assign pc_out = pc_q;
  assign ccr_out = ccr_q;
  assign instr_done_out = done_q;
  assign illegal_out = illegal_q;

  a_mul_product: assert property (@(posedge mclk_in) disable iff (srst_in) // see [RULE4] [RULE13]
    (last && cls == CLS_MUL) |=> ({x_q, acc_q} == $past(product)))
    else $error("multiply product not placed in index:accumulator");
  a_mul_flags: assert property (@(posedge mclk_in) disable iff (srst_in) // see [RULE4]
    (last && cls == CLS_MUL) |=> (!ccr_q[CCR_H] && !ccr_q[CCR_C] && ccr_q[3:1] == $past(ccr_q[3:1])))
    else $error("multiply flags wrong");
  a_tst_no_write: assert property (@(posedge mclk_in) disable iff (srst_in) // see [RULE2]
    (exec && cls == CLS_RMW && is_tst) |-> !mem_wr_out)
    else $error("test instruction wrote memory");
  a_rmw_same_addr: assert property (@(posedge mclk_in) disable iff (srst_in) // see [RULE1]
    (exec && rmw_mem && !is_tst && mem_rd_out && !byte_step) |=> (mem_wr_out && mem_addr_out == $past(mem_addr_out)))
    else $error("modify write-back not at read address");
  a_ctrl_no_bus: assert property (@(posedge mclk_in) disable iff (srst_in) // see [RULE3]
    (exec && cls == CLS_CTRL && !byte_step) |-> (!mem_rd_out && !mem_wr_out))
    else $error("control instruction used the bus");
  a_cmp_keeps: assert property (@(posedge mclk_in) disable iff (srst_in) // see [RULE7] [RULE8] [RULE9]
    (last && cls == CLS_REGMEM && !wr_reg) |=> (acc_q == $past(acc_q) && x_q == $past(x_q)))
    else $error("compare or bit test changed a register");
  a_adc_sum: assert property (@(posedge mclk_in) disable iff (srst_in) // see [RULE6]
    (last && cls == CLS_REGMEM && op == ALU_ADC)
    |=> (acc_q == $past(acc_q + mem_rdata_in + {7'h00, ccr_q[CCR_C]})))
    else $error("add with carry result wrong");
  a_eor_result: assert property (@(posedge mclk_in) disable iff (srst_in) // see [RULE10]
    (last && cls == CLS_REGMEM && op == ALU_EOR && !dest_x) |=> (acc_q == $past(acc_q ^ mem_rdata_in)))
    else $error("exclusive-or result wrong");
  a_tst_dir_len: assert property (@(posedge mclk_in) disable iff (srst_in) // see [RULE14]
    (!exec && mem_rdata_in == 8'h3d) |=> (!instr_done_out [*3] ##1 instr_done_out))
    else $error("direct test not four cycles");
  a_sta_ext_len: assert property (@(posedge mclk_in) disable iff (srst_in) // see [RULE5] [RULE11]
    (!exec && mem_rdata_in == 8'hc7) |-> ##4 mem_wr_out ##1 instr_done_out)
    else $error("extended store not five cycles");
  a_jsr_push: assert property (@(posedge mclk_in) disable iff (srst_in) // see [RULE12]
    (last && cls == CLS_JSR) |-> ($past(mem_wr_out, 1) && $past(mem_wr_out, 2)))
    else $error("call did not push the return address");

endmodule : cpu8_regmem_rmw_decode

// ### dv/mem_model.sv
`timescale 1ns/1ps
module mem_model (
  input wire logic mclk_in,
  input wire logic [15:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  int n_writes = 0;

  // Zero-latency reads; an unstrobed bus shows the inverse of the last byte so stale data never passes
  assign rdata_out = rd_in ? mem[addr_in] : ~last_q;

  always @(posedge mclk_in) begin
    if (rd_in) begin
      last_q <= mem[addr_in];
    end
    if (wr_in) begin
      mem[addr_in] <= wdata_in;
      n_writes <= n_writes + 1;
    end
  end
endmodule : mem_model

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import cpu8_regmem_rmw_decode_pkg::*;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] mem_rdata_in;
  logic [15:0] mem_addr_out;
  logic mem_rd_out;
  logic mem_wr_out;
  logic [7:0] mem_wdata_out;
  logic [7:0] acc_out;
  logic [7:0] index_out;
  logic [15:0] pc_out;
  logic [4:0] ccr_out;
  logic instr_done_out;
  logic illegal_out;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [7:0] prog [0:36] = '{8'hae, 8'h0f, 8'ha6, 8'hc8, 8'h99, 8'h42, 8'h99, 8'ha9, 8'h01, 8'hb9, 8'h40,
    8'hb1, 8'h41, 8'hc3, 8'h00, 8'h42, 8'ha8, 8'h5a, 8'hb8, 8'h43, 8'he5, 8'h75, 8'hc7, 8'h00, 8'h90,
    8'hb7, 8'h91, 8'h3c, 8'h90, 8'h3d, 8'h44, 8'h4d, 8'h6d, 8'h75, 8'hcc, 8'h01, 8'h00};

  always #10 mclk_in = ~mclk_in;

  cpu8_regmem_rmw_decode cpu8_regmem_rmw_decode_i (.mclk_in(mclk_in), .srst_in(srst_in),
    .mem_rdata_in(mem_rdata_in), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out), .acc_out(acc_out), .index_out(index_out),
    .pc_out(pc_out), .ccr_out(ccr_out), .instr_done_out(instr_done_out), .illegal_out(illegal_out));

  mem_model mem_model_i (.mclk_in(mclk_in), .addr_in(mem_addr_out), .rd_in(mem_rd_out),
    .wr_in(mem_wr_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_byte

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_count(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask : chk_count

  // Runs one instruction to its done pulse, checking length and number of bus writes
  task automatic step(input int len, input int writes, input string what, input logic ill = 1'b0);
    int n;
    int w0;
    n = 0;
    w0 = mem_model_i.n_writes;
    do begin
      @(posedge mclk_in);
      #1;
      n++;
    end while (instr_done_out !== 1'b1 && n < 40);
    chk_count(n, len, {what, " cycles"});
    chk_count(mem_model_i.n_writes - w0, writes, {what, " writes"});
    chk_byte({7'h00, illegal_out}, {7'h00, ill}, {what, " illegal"});
  endtask : step

  task automatic t_multiply;
    step(2, 0, "load index imm");
    chk_byte(index_out, 8'h0f, "index load");
    step(2, 0, "load acc imm");
    chk_byte(acc_out, 8'hc8, "acc load");
    step(2, 0, "set carry");
    chk_byte({3'h0, ccr_out}, 8'h0d, "flags after set carry");
    step(11, 0, "multiply");
    chk_byte(index_out, 8'h0b, "product high");
    chk_byte(acc_out, 8'hb8, "product low");
    chk_byte({3'h0, ccr_out}, 8'h0c, "flags after multiply");
    $display("test multiply finished");
  endtask : t_multiply

  task automatic t_arith;
    step(2, 0, "set carry");
    step(2, 0, "add carry imm");
    chk_byte(acc_out, 8'hba, "add carry imm acc");
    chk_byte({3'h0, ccr_out}, 8'h0c, "add carry imm flags");
    step(3, 0, "add carry dir");
    chk_byte(acc_out, 8'h00, "add carry dir acc");
    chk_byte({3'h0, ccr_out}, 8'h1b, "add carry dir flags");
    step(3, 0, "compare acc dir");
    chk_byte(acc_out, 8'h00, "compare keeps acc");
    chk_byte({5'h00, ccr_out[2:0]}, 8'h05, "compare acc flags");
    step(4, 0, "compare index ext");
    chk_byte(index_out, 8'h0b, "compare keeps index");
    chk_byte({5'h00, ccr_out[2:0]}, 8'h02, "compare index flags");
    step(2, 0, "xor imm");
    chk_byte(acc_out, 8'h5a, "xor imm acc");
    step(3, 0, "xor dir");
    chk_byte(acc_out, 8'h55, "xor dir acc");
    step(4, 0, "bit test ix1");
    chk_byte(acc_out, 8'h55, "bit test keeps acc");
    chk_byte({6'h00, ccr_out[2:1]}, 8'h01, "bit test flags");
    $display("test arithmetic finished");
  endtask : t_arith

  task automatic t_store_modify;
    step(5, 1, "store acc ext");
    chk_byte(mem_model_i.mem[16'h0090], 8'h55, "store ext data");
    step(4, 1, "store acc dir");
    chk_byte(mem_model_i.mem[16'h0091], 8'h55, "store dir data");
    step(5, 1, "increment dir");
    chk_byte(mem_model_i.mem[16'h0090], 8'h56, "increment written back");
    $display("test store and modify finished");
  endtask : t_store_modify

  task automatic t_test_only;
    step(4, 0, "test dir");
    chk_byte({6'h00, ccr_out[2:1]}, 8'h02, "test dir flags");
    step(3, 0, "test acc");
    chk_byte(acc_out, 8'h55, "test acc value");
    chk_byte({6'h00, ccr_out[2:1]}, 8'h00, "test acc flags");
    step(5, 0, "test ix1");
    chk_byte({6'h00, ccr_out[2:1]}, 8'h02, "test ix1 flags");
    chk_byte(mem_model_i.mem[16'h0080], 8'haa, "test leaves memory");
    $display("test non-writing finished");
  endtask : t_test_only

  task automatic t_flow;
    step(3, 0, "jump ext");
    chk_word(pc_out, 16'h0100, "jump target");
    step(5, 2, "call dir");
    chk_word(pc_out, 16'h00a0, "call target");
    chk_byte(mem_model_i.mem[16'h00ff], 8'h02, "return low pushed");
    chk_byte(mem_model_i.mem[16'h00fe], 8'h01, "return high pushed");
    step(2, 0, "no operation");
    chk_byte(acc_out, 8'h55, "acc kept");
    chk_byte(index_out, 8'h0b, "index kept");
    step(2, 0, "store acc imm refused", 1'b1);
    chk_word(pc_out, 16'h00a2, "pc past refused opcode");
    $display("test flow finished");
  endtask : t_flow

  // Reset in mid-run must restore the core and restart from the reset address
  task automatic t_reset;
    srst_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    chk_word(pc_out, RESET_PC_DEFAULT, "pc after reset");
    chk_byte(acc_out, 8'h00, "acc after reset");
    chk_byte(index_out, 8'h00, "index after reset");
    chk_byte({3'h0, ccr_out}, {3'h0, CCR_RESET}, "flags after reset");
    srst_in = 1'b0;
    step(2, 0, "load index after reset");
    chk_byte(index_out, 8'h0f, "index load after reset");
    $display("test reset finished");
  endtask : t_reset

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  initial begin
    // Unwritten memory holds no-operation so a runaway core stays harmless
    for (int a = 0; a < 65536; a++) begin
      mem_model_i.mem[a] = 8'h9d;
    end
    for (int a = 0; a < 37; a++) begin
      mem_model_i.mem[a] = prog[a];
    end
    mem_model_i.mem[16'h0040] = 8'h46;
    mem_model_i.mem[16'h0041] = 8'h01;
    mem_model_i.mem[16'h0042] = 8'h0b;
    mem_model_i.mem[16'h0043] = 8'h0f;
    mem_model_i.mem[16'h0044] = 8'h80;
    mem_model_i.mem[16'h0080] = 8'haa;
    mem_model_i.mem[16'h0100] = 8'hbd;
    mem_model_i.mem[16'h0101] = 8'ha0;
    mem_model_i.mem[16'h00a1] = 8'ha7;
    repeat (16) @(posedge mclk_in);
    #1;
    srst_in = 1'b0;
    t_multiply();
    t_arith();
    t_store_modify();
    t_test_only();
    t_flow();
    t_reset();
    finish_test();
  end

  initial begin
    #20000;
    n_mismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule : testbench
